// file: ubs_decode.sv
// utility bus select decode: apb registers, region decode, isa clock
`timescale 1ns/10ps
module ubs_decode
    import ubs_pkg::*;
(
    input  wire logic        core_clk,              // host bus clock, 125 MHz
    input  wire logic        reset,                 // async reset, active high
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb access phase
    input  wire logic        pwrite,                // apb write
    input  wire logic [11:0] paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error, unmapped address
    input  wire logic        acc_start,             // bus access begins, one pulse
    input  wire logic        acc_end,               // bus access ends, one pulse
    input  wire logic [31:0] acc_addr,              // access address
    input  wire logic        acc_from_pci,          // 1 host master, 0 isa or dma
    input  wire logic        acc_is_io,             // 1 io cycle, 0 memory cycle
    output logic      [2:0]  encoded_periph_select, // encoded peripheral select
    output logic             utility_xcvr_out_en_n, // transceiver enable, low active
    output logic             diskette_select_n,     // diskette select, low active
    output logic             pci_positive_dec,      // claim host access positively
    output logic             pci_subtractive_dec,   // leave host access subtractive
    output logic             forward_to_pci,        // pass isa or dma access upward
    output logic             isa_bus_clk            // divided isa bus clock
);
    import ubs_pkg::*;

    ubs_clk_if   cif ();

    // software visible registers
    logic [7:0]  util_sel_r;
    logic [2:0]  isa_div_r;
    logic [7:0]  dec_ctrl_r;
    // apb answer flops
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    // access tracking and registered decode outputs
    ubs_acc_e    acc_state_r;
    logic [2:0]  sel_code_r;
    logic        xcvr_oe_n_r;
    logic        pos_dec_r;
    logic        sub_dec_r;
    logic        fwd_pci_r;
    logic        floppy_n_r;
    logic        isa_clk_r;

    // apb phase and address decode
    wire         apb_acc    = psel && penable;
    wire         apb_take   = apb_acc && !pready_r;
    wire         apb_done   = apb_acc && pready_r;
    wire         hit_util   = (paddr == ADDR_UTIL_SEL);
    wire         hit_clk    = (paddr == ADDR_ISA_CLK);
    wire         hit_dec    = (paddr == ADDR_DEC_CTRL);
    wire         hit_stat   = (paddr == ADDR_STATUS);
    wire         mapped     = hit_util || hit_clk || hit_dec || hit_stat;
    wire         wr_util    = apb_done && pwrite && hit_util;
    wire         wr_clk     = apb_done && pwrite && hit_clk;
    wire         wr_dec     = apb_done && pwrite && hit_dec;
    wire         acc_busy   = (acc_state_r == ACC_BUSY);
    wire [7:0]   status_val = {acc_busy, fwd_pci_r, sub_dec_r, pos_dec_r,
                               !xcvr_oe_n_r, sel_code_r};
    wire [31:0]  rd_data    = hit_util ? {24'h0, util_sel_r} :
                              hit_clk  ? {29'h0, isa_div_r}  :
                              hit_dec  ? {24'h0, dec_ctrl_r} :
                              hit_stat ? {24'h0, status_val} : 32'h0;

    // one wait state so read data and ready both leave from flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= apb_take;
            prdata_r  <= apb_take ? rd_data : 32'h0;
            pslverr_r <= apb_take && !mapped;
        end
    end

    // register writes take effect only at the completing edge
    // divisor resets to divide by four
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            util_sel_r <= UTIL_SEL_RESET;
            isa_div_r  <= ISA_DIV_RESET;
            dec_ctrl_r <= DEC_CTRL_RESET;
        end else begin
            if (wr_util) util_sel_r <= pwdata[7:0];
            if (wr_clk)  isa_div_r  <= pwdata[2:0];
            if (wr_dec)  dec_ctrl_r <= pwdata[7:0];
        end
    end

    // enable and option bits
    wire         ext_en     = util_sel_r[BIT_EXT_BIOS_EN];
    wire         low_en     = util_sel_r[BIT_LOW_BIOS_EN];
    wire         second     = util_sel_r[BIT_SECONDARY];
    wire         ide_en     = util_sel_r[BIT_IDE_EN];
    wire         mem_sub    = dec_ctrl_r[BIT_MEM_SUBTRACT];
    wire         isa_fwd    = dec_ctrl_r[BIT_ISA_FORWARD];

    // region matches on the access address
    wire         io_low64k  = acc_is_io && (acc_addr[31:16] == 16'h0000);
    wire         ext_hit    = !acc_is_io && (acc_addr >= EXT_BIOS_LO)
                              && (acc_addr <= EXT_BIOS_HI);
    wire         low_hit    = !acc_is_io && ((acc_addr[31:16] == LOW_BIOS_1M)
                              || (acc_addr[31:16] == LOW_BIOS_4G)
                              || (acc_addr[31:16] == LOW_BIOS_4G_1M));
    wire         ide_pri    = io_low64k && ((acc_addr[15:3] == IDE_PRI_CMD[15:3])
                              || (acc_addr[15:1] == IDE_PRI_CTL[15:1]));
    wire         ide_sec    = io_low64k && ((acc_addr[15:3] == IDE_SEC_CMD[15:3])
                              || (acc_addr[15:1] == IDE_SEC_CTL[15:1]));
    // only one ide range answers, so the transceiver never fights a card
    // primary or secondary range
    wire         ide_hit    = second ? ide_sec : ide_pri;

    // selection gated by the enables
    // extended bios, host masters only
    // bit 7 clear keeps the region idle
    wire         ext_sel    = ext_hit && acc_from_pci && ext_en;
    wire         low_sel    = low_hit && low_en;
    wire         ide_sel    = ide_hit && ide_en;
    // cleared enable gives no code and no transceiver enable
    wire         bios_sel   = ext_sel || low_sel;
    wire [2:0]   sel_nxt    = bios_sel ? SEL_BIOS : (ide_sel ? SEL_IDE : SEL_IDLE);
    wire         oe_n_nxt   = !(bios_sel || ide_sel);
    // extended bios always positive; lower bios positive unless the memory control bit asks for subtractive
    wire         pos_nxt    = acc_from_pci && (ext_sel || (low_sel && !mem_sub));
    wire         sub_nxt    = acc_from_pci && low_hit && (!low_en || mem_sub);
    // enabled lower bios keeps isa and dma accesses local
    // disabled lower bios forwards only with the isa decode bit
    wire         fwd_nxt    = !acc_from_pci && low_hit && !low_en && isa_fwd;

    // an access owns its decode from start to end; starts while busy are dropped
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            acc_state_r <= ACC_IDLE;
        end else begin
            case (acc_state_r)
                ACC_IDLE: begin
                    if (acc_start) acc_state_r <= ACC_BUSY;
                end
                ACC_BUSY: begin
                    if (acc_end) acc_state_r <= ACC_IDLE;
                end
                default: acc_state_r <= ACC_IDLE;
            endcase
        end
    end

    // decode captured at access start and held, so a mid-access write is unseen
    // snapshot at access start
    // idle code all ones, diskette select never driven
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sel_code_r  <= SEL_IDLE;
            xcvr_oe_n_r <= 1'b1;
            pos_dec_r   <= 1'b0;
            sub_dec_r   <= 1'b0;
            fwd_pci_r   <= 1'b0;
            floppy_n_r  <= 1'b1;
        end else begin
            floppy_n_r <= 1'b1;
            if (!acc_busy && acc_start) begin
                sel_code_r  <= sel_nxt;
                xcvr_oe_n_r <= oe_n_nxt;
                pos_dec_r   <= pos_nxt;
                sub_dec_r   <= sub_nxt;
                fwd_pci_r   <= fwd_nxt;
            end else if (acc_busy && acc_end) begin
                sel_code_r  <= SEL_IDLE;
                xcvr_oe_n_r <= 1'b1;
                pos_dec_r   <= 1'b0;
                sub_dec_r   <= 1'b0;
                fwd_pci_r   <= 1'b0;
            end
        end
    end

    // isa clock generation; software must keep it within the isa band
    // divisor choice left to software
    // divider fed from the divisor field
    assign cif.divisor_sel = isa_div_r;

    ubs_clk_div u_clk_div (
        .core_clk (core_clk),
        .reset    (reset),
        .cif      (cif)
    );

    // retimed isa clock, one cycle behind the divider
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            isa_clk_r <= 1'b0;
        end else begin
            isa_clk_r <= cif.isa_clk;
        end
    end

    // output ports, all from flops
    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;
    assign encoded_periph_select = sel_code_r;
    assign utility_xcvr_out_en_n = xcvr_oe_n_r;
    assign diskette_select_n     = floppy_n_r;
    assign pci_positive_dec      = pos_dec_r;
    assign pci_subtractive_dec   = sub_dec_r;
    assign forward_to_pci        = fwd_pci_r;
    assign isa_bus_clk           = isa_clk_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    wire take_acc = !acc_busy && acc_start;

    chk_idle_select_code: assert property (
        !acc_busy |-> sel_code_r == SEL_IDLE && xcvr_oe_n_r && diskette_select_n)
        else $error("idle outputs not parked");
    chk_ext_bios_on: assert property (
        take_acc && acc_from_pci && ext_hit && ext_en
        |=> sel_code_r == SEL_BIOS && !xcvr_oe_n_r && pos_dec_r)
        else $error("extended bios not decoded");
    chk_ext_bios_off: assert property (
        take_acc && ext_hit && !ext_en |=> sel_code_r == SEL_IDLE && xcvr_oe_n_r)
        else $error("extended bios decoded while disabled");
    chk_low_bios_code: assert property (
        take_acc && low_hit && low_en |=> sel_code_r == SEL_BIOS)
        else $error("lower bios select missing");
    chk_low_bios_claim: assert property (
        take_acc && acc_from_pci && low_hit && low_en
        |=> pos_dec_r == !$past(mem_sub) && sub_dec_r == $past(mem_sub))
        else $error("lower bios decode mode wrong");
    chk_isa_no_forward: assert property (
        take_acc && !acc_from_pci && low_hit && low_en |=> !forward_to_pci)
        else $error("enabled lower bios forwarded");
    chk_isa_fwd_gate: assert property (
        take_acc && !acc_from_pci && low_hit && !low_en
        |=> forward_to_pci == $past(isa_fwd) && sel_code_r == SEL_IDLE)
        else $error("disabled lower bios forward wrong");
    chk_ide_select_gate: assert property (
        take_acc && ide_hit |=> (sel_code_r == SEL_IDE) == $past(ide_en))
        else $error("ide select does not follow enable");
    chk_ide_wrong_range: assert property (
        take_acc && (second ? ide_pri : ide_sec) && !bios_sel |=> sel_code_r == SEL_IDLE)
        else $error("unselected ide range decoded");
    chk_hold_in_access: assert property (
        acc_busy && !acc_end |=> $stable(sel_code_r) && $stable(xcvr_oe_n_r))
        else $error("decode changed mid access");
    chk_div_reset_field: assert property (
        $rose(isa_clk_r) && isa_div_r == DIV_SEL_BY4 && $past(isa_div_r, 4) == DIV_SEL_BY4
        && $past(isa_div_r, 8) == DIV_SEL_BY4 |-> ##2 !isa_clk_r ##2 isa_clk_r)
        else $error("isa clock not divide by four");

    // claims belong to host accesses, forwarding to isa or dma accesses only
    chk_claim_host_only: assert property (
        take_acc && !acc_from_pci |=> !pci_positive_dec && !pci_subtractive_dec)
        else $error("claim raised for isa or dma access");
    chk_fwd_isa_only: assert property (
        take_acc && acc_from_pci |=> !forward_to_pci)
        else $error("host access forwarded upward");
    chk_io_no_claim: assert property (
        take_acc && acc_is_io |=> !pos_dec_r && !sub_dec_r && !fwd_pci_r)
        else $error("io access claimed as memory");
    // a clear enable must leave the transceiver off, or it fights the data bus
    chk_low_bios_off: assert property (
        take_acc && low_hit && !low_en |=> sel_code_r == SEL_IDLE && xcvr_oe_n_r)
        else $error("lower bios decoded while disabled");
    chk_all_disabled: assert property (
        take_acc && !ext_en && !low_en && !ide_en |=> utility_xcvr_out_en_n)
        else $error("transceiver on with all enables clear");
    // a register write during an access must not leak into its decode
    chk_write_unseen: assert property (
        acc_busy && !acc_end && wr_util |=> $stable(sel_code_r) && $stable(pos_dec_r))
        else $error("mid access write changed decode");

    cov_ext_bios: cover property (take_acc && ext_sel);
    cov_isa_forward: cover property (take_acc && fwd_nxt);
    cov_ide_secondary: cover property (take_acc && ide_sel && second);
    cov_apb_write: cover property (wr_util ##[1:20] take_acc);
    cov_low_bios_sub: cover property (take_acc && low_sel && mem_sub);

endmodule : ubs_decode

// file: ubs_pkg.sv
// constants shared by the utility bus select decode block
package ubs_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  REG_IDX_UTIL_SEL   = 8'h4E;
    localparam logic [7:0]  REG_IDX_ISA_CLK    = 8'h40;
    localparam logic [7:0]  REG_IDX_DEC_CTRL   = 8'h41;
    localparam logic [7:0]  REG_IDX_STATUS     = 8'h42;
    localparam logic [11:0] ADDR_UTIL_SEL      = {2'h0, REG_IDX_UTIL_SEL, 2'h0};
    localparam logic [11:0] ADDR_ISA_CLK       = {2'h0, REG_IDX_ISA_CLK, 2'h0};
    localparam logic [11:0] ADDR_DEC_CTRL      = {2'h0, REG_IDX_DEC_CTRL, 2'h0};
    localparam logic [11:0] ADDR_STATUS        = {2'h0, REG_IDX_STATUS, 2'h0};

    // values after reset
    localparam logic [7:0]  UTIL_SEL_RESET     = 8'h07;
    localparam logic [2:0]  ISA_DIV_RESET      = 3'h0;
    localparam logic [7:0]  DEC_CTRL_RESET     = 8'h00;

    // field positions in the utility select enables register
    localparam int          BIT_EXT_BIOS_EN    = 7;
    localparam int          BIT_LOW_BIOS_EN    = 6;
    localparam int          BIT_SECONDARY      = 5;
    localparam int          BIT_IDE_EN         = 4;
    // field positions in the decode control register
    localparam int          BIT_MEM_SUBTRACT   = 4;
    localparam int          BIT_ISA_FORWARD    = 3;

    // divisor field encodings and the counts they select
    localparam logic [2:0]  DIV_SEL_BY4        = 3'h0;
    localparam logic [2:0]  DIV_SEL_BY3        = 3'h1;
    localparam logic [2:0]  DIV_COUNT_4        = 3'h4;
    localparam logic [2:0]  DIV_COUNT_3        = 3'h3;
    localparam logic [2:0]  DIV_CNT_RESET      = 3'h3;

    // encoded peripheral select codes
    localparam logic [2:0]  SEL_IDLE           = 3'h7;
    localparam logic [2:0]  SEL_BIOS           = 3'h0;
    localparam logic [2:0]  SEL_IDE            = 3'h5;

    // address regions
    localparam logic [31:0] EXT_BIOS_LO        = 32'hFFF80000;
    localparam logic [31:0] EXT_BIOS_HI        = 32'hFFFDFFFF;
    localparam logic [15:0] LOW_BIOS_1M        = 16'h000E;
    localparam logic [15:0] LOW_BIOS_4G        = 16'hFFFE;
    localparam logic [15:0] LOW_BIOS_4G_1M     = 16'hFFEE;
    localparam logic [15:0] IDE_PRI_CMD        = 16'h01F0;
    localparam logic [15:0] IDE_SEC_CMD        = 16'h0170;
    localparam logic [15:0] IDE_PRI_CTL        = 16'h03F6;
    localparam logic [15:0] IDE_SEC_CTL        = 16'h0376;

    // access tracking states
    typedef enum logic [0:0] {
        ACC_IDLE,
        ACC_BUSY
    } ubs_acc_e;

endpackage : ubs_pkg

// file: ubs_clk_if.sv
// carrier between decode top and isa clock divider
`timescale 1ns/10ps
interface ubs_clk_if;
    logic [2:0] divisor_sel;   // divisor field from software
    logic       isa_clk;       // divided isa bus clock

    modport gen (input divisor_sel, output isa_clk);
    modport ctl (output divisor_sel, input isa_clk);
endinterface : ubs_clk_if

// file: ubs_clk_div.sv
// isa bus clock divider off the host bus clock
`timescale 1ns/10ps
module ubs_clk_div
    import ubs_pkg::*;
(
    input  wire logic core_clk,   // host bus clock
    input  wire logic reset,      // async reset, active high
    ubs_clk_if.gen    cif         // divisor in, clock out
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] cur_div_r;
    logic [2:0] cur_div_nxt;
    logic       isa_clk_r;
    logic       isa_clk_nxt;
    logic       wrap;
    logic [2:0] new_div;

    // reserved encodings fall back to divide by four
    // divisor encoding map
    assign new_div     = (cif.divisor_sel == DIV_SEL_BY3) ? DIV_COUNT_3 : DIV_COUNT_4;
    // divisor only swaps at period end so no runt pulse reaches the isa bus
    // integer division count
    assign wrap        = (cnt_r == (cur_div_r - 3'h1));
    assign cnt_nxt     = wrap ? 3'h0 : (cnt_r + 3'h1);
    assign cur_div_nxt = wrap ? new_div : cur_div_r;
    assign isa_clk_nxt = (cnt_nxt < (cur_div_nxt >> 1));
    assign cif.isa_clk = isa_clk_r;

    // counter, active divisor and clock flop
    // reset to divide by four
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_r     <= DIV_CNT_RESET;
            cur_div_r <= DIV_COUNT_4;
            isa_clk_r <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            cur_div_r <= cur_div_nxt;
            isa_clk_r <= isa_clk_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_div_four_shape: assert property (
        $rose(isa_clk_r) && cur_div_r == DIV_COUNT_4 |-> isa_clk_r[*2] ##1 !isa_clk_r[*2])
        else $error("divide by four shape wrong");
    chk_div_three_shape: assert property (
        $rose(isa_clk_r) && cur_div_r == DIV_COUNT_3 |-> ##1 !isa_clk_r[*2] ##1 isa_clk_r)
        else $error("divide by three shape wrong");
    chk_div_encode_map: assert property (
        wrap && cif.divisor_sel == DIV_SEL_BY3 |=> cur_div_r == DIV_COUNT_3)
        else $error("divisor encoding not applied");

endmodule : ubs_clk_div

// file: ubs_periph_model.sv
// behavioural utility bus peripherals behind the data transceiver
`timescale 1ns/10ps
module ubs_periph_model
    import ubs_pkg::*;
#(
    parameter logic [7:0] BIOS_BYTE = 8'h5A,   // arbitrary flash content
    parameter logic [7:0] IDE_BYTE  = 8'hC3    // arbitrary drive status
)(
    input  wire logic       core_clk,              // host bus clock
    input  wire logic [2:0] encoded_periph_select, // encoded select from decode
    input  wire logic       utility_xcvr_out_en_n, // transceiver enable, low active
    output logic      [7:0] xbus_data              // byte seen through transceiver
);
    logic [7:0] stale_r = 8'h00;  // inverse of last value, so a released bus never looks valid

    // released bus toggles every cycle
    always_ff @(posedge core_clk) begin
        stale_r <= ~xbus_data;
    end

    always_comb begin
        xbus_data = stale_r;
        if (!utility_xcvr_out_en_n && encoded_periph_select == SEL_BIOS) begin
            xbus_data = BIOS_BYTE;
        end else if (!utility_xcvr_out_en_n && encoded_periph_select == SEL_IDE) begin
            xbus_data = IDE_BYTE;
        end
    end
endmodule : ubs_periph_model

// file: utility_bus_select_decode_bench.sv
// self-checking bench for the utility bus select decode block
`timescale 1ns/10ps
module utility_bus_select_decode_bench;
    import ubs_pkg::*;
    typedef struct packed {
        logic [7:0]  u;
        logic [7:0]  d;
        logic [31:0] a;
        logic        h;
        logic        io;
        logic [7:0]  x;
    } ubs_case_s;
    // expected {select, oe_n, diskette_n, pos, sub, fwd}
    localparam logic [7:0] IDLE_V = {SEL_IDLE, 5'b11000};
    localparam logic [7:0] BIOS_P = {SEL_BIOS, 5'b01100};
    localparam logic [7:0] BIOS_S = {SEL_BIOS, 5'b01010};
    localparam logic [7:0] BIOS_N = {SEL_BIOS, 5'b01000};
    localparam logic [7:0] IDE_V  = {SEL_IDE, 5'b01000};
    localparam logic [7:0] SUB_V  = {SEL_IDLE, 5'b11010};
    localparam logic [7:0] FWD_V  = {SEL_IDLE, 5'b11001};
    logic        core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        acc_start = 1'b0, acc_end = 1'b0, acc_from_pci = 1'b0, acc_is_io = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, acc_addr = 32'h0, prdata, rd;
    logic        pready, pslverr, er, utility_xcvr_out_en_n, diskette_select_n;
    logic        pci_positive_dec, pci_subtractive_dec, forward_to_pci, isa_bus_clk;
    logic [2:0]  encoded_periph_select;
    logic [7:0]  xbus_data, dec_now;
    int          failures = 0, cmp_count = 0, i, p;
    ubs_case_s   tc [22];

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    assign dec_now = {encoded_periph_select, utility_xcvr_out_en_n, diskette_select_n,
                      pci_positive_dec, pci_subtractive_dec, forward_to_pci};

    ubs_decode i_ubs_decode (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acc_start(acc_start), .acc_end(acc_end),
        .acc_addr(acc_addr), .acc_from_pci(acc_from_pci), .acc_is_io(acc_is_io),
        .encoded_periph_select(encoded_periph_select),
        .utility_xcvr_out_en_n(utility_xcvr_out_en_n), .diskette_select_n(diskette_select_n),
        .pci_positive_dec(pci_positive_dec), .pci_subtractive_dec(pci_subtractive_dec),
        .forward_to_pci(forward_to_pci), .isa_bus_clk(isa_bus_clk)
    );
    ubs_periph_model i_ubs_periph_model (
        .core_clk(core_clk), .encoded_periph_select(encoded_periph_select),
        .utility_xcvr_out_en_n(utility_xcvr_out_en_n), .xbus_data(xbus_data)
    );

    task automatic finish_test;
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_dec(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t decode got %h exp %h", $time, got, exp);
        end
    endtask : cmp_dec

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        cmp_word(rd, exp);
        cmp_word({31'h0, er}, {31'h0, e});
    endtask : chk_rd

    task automatic acc_begin(input logic [31:0] a, input logic h, input logic io);
        @(posedge core_clk);
        acc_start <= 1'b1;
        acc_addr <= a;
        acc_from_pci <= h;
        acc_is_io <= io;
        @(posedge core_clk);
        acc_start <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : acc_begin

    task automatic acc_finish;
        @(posedge core_clk);
        acc_end <= 1'b1;
        @(posedge core_clk);
        acc_end <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        cmp_dec(dec_now, IDLE_V);
    endtask : acc_finish

    // rise-to-rise distance of the isa clock, in core cycles
    task automatic period(output int c);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (isa_bus_clk !== 1'b0 && n < 20);
        do begin
            @(posedge core_clk);
            n++;
        end while (isa_bus_clk !== 1'b1 && n < 20);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (isa_bus_clk !== 1'b0 && c < 20);
        do begin
            @(posedge core_clk);
            c++;
        end while (isa_bus_clk !== 1'b1 && c < 20);
        if (n >= 20 || c >= 20) begin
            failures++;
            finish_test();
        end
    endtask : period

    // decode table: utility enables, decode ctrl, address, host, io, expected
    initial begin
        tc[0]  = '{8'h80, 8'h00, 32'hFFF80000, 1'b1, 1'b0, BIOS_P};
        tc[1]  = '{8'h80, 8'h00, 32'hFFFDFFFF, 1'b1, 1'b0, BIOS_P};
        tc[2]  = '{8'h80, 8'h00, 32'hFFFE0000, 1'b1, 1'b0, SUB_V};
        tc[3]  = '{8'h80, 8'h00, 32'hFFF80000, 1'b0, 1'b0, IDLE_V};
        tc[4]  = '{8'h00, 8'h00, 32'hFFF80000, 1'b1, 1'b0, IDLE_V};
        tc[5]  = '{8'h40, 8'h00, 32'h000E0000, 1'b1, 1'b0, BIOS_P};
        tc[6]  = '{8'h40, 8'h00, 32'hFFFEFFFF, 1'b1, 1'b0, BIOS_P};
        tc[7]  = '{8'h40, 8'h00, 32'hFFEE0000, 1'b1, 1'b0, BIOS_P};
        tc[8]  = '{8'h40, 8'h10, 32'h000E8000, 1'b1, 1'b0, BIOS_S};
        tc[9]  = '{8'h40, 8'h08, 32'h000E0000, 1'b0, 1'b0, BIOS_N};
        tc[10] = '{8'h00, 8'h08, 32'h000EFFFF, 1'b0, 1'b0, FWD_V};
        tc[11] = '{8'h00, 8'h00, 32'h000E0000, 1'b0, 1'b0, IDLE_V};
        tc[12] = '{8'h00, 8'h00, 32'h000E0000, 1'b1, 1'b0, SUB_V};
        tc[13] = '{8'h10, 8'h00, 32'h000001F0, 1'b1, 1'b1, IDE_V};
        tc[14] = '{8'h10, 8'h00, 32'h000003F7, 1'b0, 1'b1, IDE_V};
        tc[15] = '{8'h10, 8'h00, 32'h00000177, 1'b1, 1'b1, IDLE_V};
        tc[16] = '{8'h30, 8'h00, 32'h00000170, 1'b1, 1'b1, IDE_V};
        tc[17] = '{8'h30, 8'h00, 32'h00000377, 1'b1, 1'b1, IDE_V};
        tc[18] = '{8'h30, 8'h00, 32'h000001F0, 1'b1, 1'b1, IDLE_V};
        tc[19] = '{8'h00, 8'h00, 32'h000001F0, 1'b1, 1'b1, IDLE_V};
        tc[20] = '{8'h10, 8'h00, 32'h000001F0, 1'b1, 1'b0, IDLE_V};
        tc[21] = '{8'h40, 8'h00, 32'h000E0000, 1'b1, 1'b1, IDLE_V};
    end

    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        chk_rd(ADDR_UTIL_SEL, 32'h07, 1'b0);
        chk_rd(ADDR_ISA_CLK, 32'h0, 1'b0);
        chk_rd(ADDR_DEC_CTRL, 32'h0, 1'b0);
        chk_rd(12'h000, 32'h0, 1'b1);
        period(p);
        cmp_word(p, 32'h4);
        // software picks the divisor; reserved codes only probed
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_ISA_CLK, i * 3 % 8);
            period(p);
            period(p);
            cmp_word(p, (i == 3) ? 32'h3 : 32'h4);
        end
        apb(1'b1, ADDR_UTIL_SEL, 32'hFFFFFFA5);
        chk_rd(ADDR_UTIL_SEL, 32'hA5, 1'b0);
        for (i = 0; i < 22; i++) begin
            apb(1'b1, ADDR_UTIL_SEL, {24'h0, tc[i].u});
            apb(1'b1, ADDR_DEC_CTRL, {24'h0, tc[i].d});
            acc_begin(tc[i].a, tc[i].h, tc[i].io);
            cmp_dec(dec_now, tc[i].x);
            if (tc[i].x[4] === 1'b0) begin
                cmp_word(xbus_data, (tc[i].x[7:5] == SEL_IDE) ? 32'hC3 : 32'h5A);
            end
            acc_finish();
        end
        // enable change and a second start in mid-access keep the old decode
        apb(1'b1, ADDR_UTIL_SEL, 32'h80);
        acc_begin(32'hFFF80000, 1'b1, 1'b0);
        apb(1'b1, ADDR_UTIL_SEL, 32'h00);
        acc_begin(32'h000E0000, 1'b1, 1'b0);
        chk_rd(ADDR_STATUS, 32'h98, 1'b0);
        cmp_dec(dec_now, BIOS_P);
        acc_finish();
        acc_begin(32'hFFF80000, 1'b1, 1'b0);
        cmp_dec(dec_now, IDLE_V);
        acc_finish();
        finish_test();
    end
endmodule : utility_bus_select_decode_bench
